// [core/poll_master_regs.vh]
// constants for the serial bus master poller
`ifndef POLL_MASTER_REGS_VH
`define POLL_MASTER_REGS_VH
`define ADDR_BROADCAST 8'h00
`define ADDR_UNIT_MAX 8'hF7
`define MISS_LIMIT 2'h3
`define DIAG_LEN 8'h03
`define DIAG_BYTES 2'h3
`define DIAG_PERIOD_NS 1000000
`define CLK_PERIOD_NS 4
`define DIAG_PERIOD_CYC (`DIAG_PERIOD_NS / `CLK_PERIOD_NS)
`define TMO_W 32
`endif

// [core/cycle_timer.v]
// down-counting timer that pulses when a loaded count expires
`timescale 1ns/10ps
`default_nettype none
module cycle_timer (
   input wire i_sys_clk,
   input wire i_sys_rst,
   input wire i_ce,
   input wire i_load,
   input wire i_stop,
   input wire [31:0] i_count,
   output reg o_expired,
   output wire o_running
);
   reg [31:0] remain;
   reg run;
   assign o_running = run;
   always @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         remain <= 32'h00000000;
         run <= 1'b0;
         o_expired <= 1'b0;
      end else if (i_ce) begin
         o_expired <= 1'b0;
         if (i_load) begin
            remain <= (i_count == 32'h00000000) ? 32'h00000001 : i_count;
            run <= 1'b1;
         end else if (i_stop) begin
            run <= 1'b0;
         end else if (run) begin
            if (remain == 32'h00000001) begin
               run <= 1'b0;
               o_expired <= 1'b1;
            end else begin
               remain <= remain - 32'h00000001;
            end
         end
      end
   end
endmodule // cycle_timer
`default_nettype wire

// [core/diag_packet.v]
// serialiser for the three-byte diagnose packet
`timescale 1ns/10ps
`default_nettype none
`include "poll_master_regs.vh"
module diag_packet (
   input wire i_sys_clk,
   input wire i_sys_rst,
   input wire i_ce,
   input wire i_start,
   input wire [7:0] i_page,
   input wire [7:0] i_module,
   input wire i_ready,
   output reg o_valid,
   output reg [7:0] o_data,
   output wire o_busy
);
   reg [1:0] idx;
   reg [7:0] page;
   reg [7:0] modnum;
   assign o_busy = o_valid;
   always @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         idx <= 2'h0;
         page <= 8'h00;
         modnum <= 8'h00;
         o_valid <= 1'b0;
         o_data <= 8'h00;
      end else if (i_ce) begin
         if (!o_valid && i_start) begin
            page <= i_page;
            modnum <= i_module;
            idx <= 2'h1;
            o_valid <= 1'b1;
            o_data <= `DIAG_LEN;
         end else if (o_valid && i_ready) begin
            if (idx == `DIAG_BYTES) begin
               o_valid <= 1'b0;
               idx <= 2'h0;
            end else begin
               idx <= idx + 2'h1;
               o_data <= (idx == 2'h1) ? page : modnum;
            end
         end
      end
   end
endmodule // diag_packet
`default_nettype wire

// [core/poll_master.v]
// serial field-bus master: one request at a time, timeout and diagnostic mode
`timescale 1ns/10ps
`default_nettype none
`include "poll_master_regs.vh"
module poll_master (
   input wire i_sys_clk,
   input wire i_sys_rst,
   input wire i_ce,
   input wire i_req_valid,
   input wire [7:0] i_req_addr,
   input wire [7:0] i_req_func,
   output wire o_req_ready,
   output wire o_req_reject,
   input wire [31:0] i_timeout_cyc,
   input wire [7:0] i_diag_page,
   input wire [7:0] i_diag_module,
   output reg o_tx_valid,
   output reg [7:0] o_tx_addr,
   output reg [7:0] o_tx_func,
   input wire i_tx_ready,
   input wire i_rx_valid,
   input wire [7:0] i_rx_addr,
   input wire i_rx_exception,
   output reg o_done,
   output reg o_done_exception,
   output reg o_done_timeout,
   output reg o_done_broadcast,
   output reg o_diag_mode,
   output wire o_diag_valid,
   output wire [7:0] o_diag_data,
   input wire i_diag_ready,
   output wire o_busy
);
   localparam ST_IDLE = 2'h0;
   localparam ST_SEND = 2'h1;
   localparam ST_WAIT = 2'h2;
   reg [1:0] state;
   reg [1:0] next_state;
   reg [1:0] miss_cnt;
   reg bcast;
   wire tmo_expired;
   wire tmo_running;
   wire diag_expired;
   wire diag_running;
   wire diag_busy;
   wire addr_bcast;
   wire addr_unit;
   wire rx_match;
   wire take;
   wire sent;
   wire diag_kick;

   assign addr_bcast = (i_req_addr == `ADDR_BROADCAST);
   assign addr_unit = (i_req_addr != `ADDR_BROADCAST) && (i_req_addr <= `ADDR_UNIT_MAX);
   assign o_req_ready = (state == ST_IDLE);
   assign o_busy = (state != ST_IDLE);
   assign take = i_ce && o_req_ready && i_req_valid && (addr_bcast || addr_unit);
   assign o_req_reject = o_req_ready && i_req_valid && !(addr_bcast || addr_unit);
   assign sent = i_ce && (state == ST_SEND) && i_tx_ready;
   // only a reply from the polled server counts
   assign rx_match = i_rx_valid && (state == ST_WAIT) && (i_rx_addr == o_tx_addr);

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (take) begin
               next_state = ST_SEND;
            end
         end
         ST_SEND: begin
            if (sent) begin
               next_state = bcast ? ST_IDLE : ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (rx_match || tmo_expired) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         state <= ST_IDLE;
         bcast <= 1'b0;
         o_tx_valid <= 1'b0;
         o_tx_addr <= 8'h00;
         o_tx_func <= 8'h00;
         o_done <= 1'b0;
         o_done_exception <= 1'b0;
         o_done_timeout <= 1'b0;
         o_done_broadcast <= 1'b0;
         miss_cnt <= 2'h0;
         o_diag_mode <= 1'b0;
      end else if (i_ce) begin
         state <= next_state;
         o_done <= 1'b0;
         o_done_exception <= 1'b0;
         o_done_timeout <= 1'b0;
         o_done_broadcast <= 1'b0;
         if (take) begin
            o_tx_addr <= i_req_addr;
            o_tx_func <= i_req_func;
            bcast <= addr_bcast;
            o_tx_valid <= 1'b1;
         end else if (sent) begin
            o_tx_valid <= 1'b0;
         end
         if (sent && bcast) begin
            o_done <= 1'b1;
            o_done_broadcast <= 1'b1;
         end
         if (rx_match) begin
            o_done <= 1'b1;
            o_done_exception <= i_rx_exception;
            miss_cnt <= 2'h0;
            if (!i_rx_exception) begin
               o_diag_mode <= 1'b0;
            end
         end else if (state == ST_WAIT && tmo_expired) begin
            o_done <= 1'b1;
            o_done_timeout <= 1'b1;
            if (miss_cnt == `MISS_LIMIT - 2'h1) begin
               o_diag_mode <= 1'b1;
            end
            if (miss_cnt != `MISS_LIMIT) begin
               miss_cnt <= miss_cnt + 2'h1;
            end
         end
      end
   end

   cycle_timer u_resp_timer (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_ce(i_ce),
      .i_load(sent && !bcast),
      .i_stop(rx_match),
      .i_count(i_timeout_cyc),
      .o_expired(tmo_expired),
      .o_running(tmo_running)
   );

   assign diag_kick = o_diag_mode && !diag_running && !diag_busy;
   cycle_timer u_diag_timer (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_ce(i_ce),
      .i_load(diag_kick),
      .i_stop(!o_diag_mode),
      .i_count(`DIAG_PERIOD_CYC),
      .o_expired(diag_expired),
      .o_running(diag_running)
   );

   diag_packet u_diag_pkt (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_ce(i_ce),
      .i_start(diag_kick),
      .i_page(i_diag_page),
      .i_module(i_diag_module),
      .i_ready(i_diag_ready),
      .o_valid(o_diag_valid),
      .o_data(o_diag_data),
      .o_busy(diag_busy)
   );
endmodule // poll_master
`default_nettype wire

// [verif/poll_master_asserts.sv]
// port assertions for the poll master
`timescale 1ns/10ps
`default_nettype none
module poll_master_asserts (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic i_req_valid,
   input wire logic [7:0] i_req_addr,
   input wire logic o_req_ready,
   input wire logic o_req_reject,
   input wire logic o_tx_valid,
   input wire logic [7:0] o_tx_addr,
   input wire logic i_tx_ready,
   input wire logic o_done,
   input wire logic o_done_exception,
   input wire logic o_done_timeout,
   input wire logic o_diag_mode,
   input wire logic o_diag_valid,
   input wire logic [7:0] o_diag_data,
   input wire logic i_diag_ready
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   property p_rsv; i_req_valid && o_req_ready && i_req_addr > 8'hF7 |-> o_req_reject; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved not refused");
   property p_take;
      i_ce && i_req_valid && o_req_ready && !o_req_reject |=>
         o_tx_valid && o_tx_addr == $past(i_req_addr);
   endproperty
   a_take: assert property (p_take) else $error("wrong target");
   property p_one; o_tx_valid |-> !o_req_ready; endproperty
   a_one: assert property (p_one) else $error("second request open");
   property p_bc; o_tx_valid && i_tx_ready && o_tx_addr == 8'h00 |=> o_req_ready; endproperty
   a_bc: assert property (p_bc) else $error("broadcast waited");
   property p_tmo; o_done_timeout |-> o_done && o_req_ready; endproperty
   a_tmo: assert property (p_tmo) else $error("timeout not freed");
   property p_ent;
      $rose(o_diag_mode) |-> o_done_timeout ##[1:3] o_diag_valid && o_diag_data == 8'h03;
   endproperty
   a_ent: assert property (p_ent) else $error("bad diag entry");
   property p_hold; o_diag_valid && !i_diag_ready |=> o_diag_valid && $stable(o_diag_data); endproperty
   a_hold: assert property (p_hold) else $error("diag byte lost");
   property p_lv; $fell(o_diag_mode) |-> o_done && !o_done_exception && !o_done_timeout; endproperty
   a_lv: assert property (p_lv) else $error("bad diag exit");
endmodule // poll_master_asserts
bind poll_master poll_master_asserts i_poll_master_asserts (.*);
`default_nettype wire

// [verif/server_model.sv]
// passive server on the shared line
`timescale 1ns/10ps
`default_nettype none
module server_model (
   input wire logic clk,
   input wire logic tx_valid,
   input wire logic [7:0] tx_addr,
   input wire logic [1:0] mode,
   input wire logic [7:0] dly,
   output logic tx_ready,
   output logic rx_valid,
   output logic [7:0] rx_addr,
   output logic rx_exc
);
   logic [7:0] a;
   initial begin
      {tx_ready, rx_valid, rx_exc, rx_addr} = 11'h0FF;
      forever begin
         @(negedge clk);
         if (tx_valid) begin
            a = tx_addr;
            tx_ready = 1;
            @(negedge clk);
            tx_ready = 0;
            if (a != 8'h00 && mode != 2) begin
               repeat (dly) @(negedge clk);
               rx_valid = 1;
               rx_addr = a;
               rx_exc = mode[0];
               @(negedge clk);
               {rx_valid, rx_addr, rx_exc} = {1'b0, ~a, ~rx_exc};
            end
         end
      end
   end
endmodule // server_model
`default_nettype wire

// [verif/tb_top.sv]
// testbench for the poll master
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic i_sys_clk = 0, i_sys_rst = 1, i_ce = 1, i_req_valid = 0, i_diag_ready = 0;
   logic [7:0] i_req_addr = 0, i_req_func = 0, i_diag_page = 8'h01, i_diag_module = 8'h03;
   logic [31:0] i_timeout_cyc = 20;
   logic [7:0] i_rx_addr, o_tx_addr, o_tx_func, o_diag_data, dly = 1, f;
   logic i_tx_ready, i_rx_valid, i_rx_exception, o_req_ready, o_req_reject, o_tx_valid, o_busy;
   logic o_done, o_done_exception, o_done_timeout, o_done_broadcast, o_diag_mode, o_diag_valid;
   logic [1:0] mode = 0;
   int bad_count = 0, checked = 0, cyc = 0, l;
   poll_master i_poll_master (.*);
   server_model i_server_model (.clk(i_sys_clk), .tx_valid(o_tx_valid), .tx_addr(o_tx_addr),
      .mode(mode), .dly(dly), .tx_ready(i_tx_ready), .rx_valid(i_rx_valid),
      .rx_addr(i_rx_addr), .rx_exc(i_rx_exception));
   always #2 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count++;
         results();
      end
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task results;
      $display("checks=%0d errors=%0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // flags: ready, diag, exception, timeout, broadcast, done
   task automatic run(input logic [7:0] a, input logic [1:0] m);
      mode = m;
      repeat (2) @(negedge i_sys_clk);
      {i_req_valid, i_req_addr, i_req_func} = {1'b1, a, ~a};
      @(negedge i_sys_clk);
      i_req_valid = 0;
      for (l = 0; o_done !== 1'b1 && l < 200; l++) @(posedge i_sys_clk) #1;
      f = {2'b00, o_req_ready, o_diag_mode, o_done_exception, o_done_timeout, o_done_broadcast, o_done};
   endtask
   task t_unicast;
      run(8'h01, 0);
      chk(f, 8'h21);
      chk(o_tx_func, 8'hFE);
      run(8'hF7, 0);
      chk(f, 8'h21);
   endtask
   task t_bcast;
      run(8'h00, 0);
      chk(f, 8'h23);
      chk(l < 6, 1);
   endtask
   task t_rsv;
      for (int a = 248; a < 256; a += 7) begin
         @(negedge i_sys_clk);
         {i_req_valid, i_req_addr} = {1'b1, a[7:0]};
         @(negedge i_sys_clk);
         chk({o_req_reject, o_busy}, 8'h02);
         i_req_valid = 0;
      end
   endtask
   task t_ce;
      @(negedge i_sys_clk);
      {i_ce, i_req_valid, i_req_addr} = {1'b0, 1'b1, 8'h05};
      repeat (2) @(negedge i_sys_clk);
      chk({o_busy, o_tx_valid}, 8'h00);
      {i_ce, i_req_valid} = 2'b10;
      @(negedge i_sys_clk);
      chk({o_busy, o_tx_valid}, 8'h00);
   endtask
   task t_tmo;
      for (int n = 20; n <= 40; n += 20) begin
         i_timeout_cyc = n;
         run(8'h22, 2);
         chk(f, 8'h25);
         chk(l >= n && l <= n + 6, 1);
      end
   endtask
   task t_exc;
      dly = 12;
      run(8'h30, 1);
      chk(f, 8'h29);
      dly = 1;
   endtask
   task t_diag;
      logic [7:0] pk[3];
      pk = '{8'h03, i_diag_page, i_diag_module};
      i_timeout_cyc = 20;
      for (int k = 0; k < 3; k++) begin
         run(8'h44, 2);
         chk(f, k == 2 ? 8'h35 : 8'h25);
      end
      for (int k = 0; k < 3; k++) begin
         for (int w = 0; w < 8 && o_diag_valid !== 1'b1; w++) @(negedge i_sys_clk);
         chk(o_diag_data, pk[k]);
         i_diag_ready = 1;
         @(negedge i_sys_clk);
         i_diag_ready = 0;
      end
      run(8'h44, 1);
      chk(f, 8'h39);
      run(8'h44, 0);
      chk(f, 8'h21);
   endtask
   initial begin
      repeat (16) @(negedge i_sys_clk);
      i_sys_rst = 0;
      t_unicast();
      t_bcast();
      t_rsv();
      t_ce();
      t_tmo();
      t_exc();
      t_diag();
      results();
   end
endmodule // tb_top
`default_nettype wire
